//--- inc/motor_step_pkg.sv
package motor_step_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_PHASE_STATE = 4'h0;
	localparam logic [3:0] ADDR_CHANNEL_PARITY = 4'h4;
	localparam logic [3:0] ADDR_CONTROL = 4'h8;
	localparam logic [3:0] ADDR_POLARITY = 4'hC;
	localparam logic [7:0] PHASE_STATE_RESET = 8'h00;
	localparam logic [7:0] CHANNEL_PARITY_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] POLARITY_RESET = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int INPUT_SELECT_HI = 7;
	localparam int INPUT_SELECT_LO = 6;
	localparam int EDGE_RELATION_BIT = 7;
	localparam int READ_PARITY_BIT = 6;
	localparam int CHANNEL_HI = 5;
	// Control register bits
	localparam int CTRL_DIRECT_ACCESS = 0;
	localparam int CTRL_SENSOR_SELECT = 1;
	localparam int CTRL_VOLT_CURR = 2;
	localparam int CTRL_PRE_DEMAG = 3;
	localparam int CTRL_POST_LO = 4;
	localparam int CTRL_POST_HI = 5;
	localparam int CTRL_OUTPUT_ENABLE = 6;
	// ****************************************
	// Codes
	// ****************************************
	localparam logic [1:0] SEL_PHASE_A = 2'h0;
	localparam logic [1:0] SEL_PHASE_B = 2'h1;
	localparam logic [1:0] SEL_PHASE_C = 2'h2;
	localparam logic [1:0] MODE_EVEN = 2'h0;
	localparam logic [1:0] MODE_ODD = 2'h1;
	localparam logic [1:0] MODE_ALTERNATE = 2'h2;
	localparam logic [1:0] MODE_ALL = 2'h3;
	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage

//--- core/phase_input_mux.sv
`timescale 1ns/1ps
module phase_input_mux (
	input wire logic [1:0] input_select,
	input wire logic phase_input_a,
	input wire logic phase_input_b,
	input wire logic phase_input_c,
	output logic comparator_input,
	output logic comparator_connected
);
	// ****************************************
	// Back-EMF input routing
	// ****************************************
	always_comb begin
		comparator_connected = 1'b1;
		case (input_select)
			motor_step_pkg::SEL_PHASE_A: comparator_input = phase_input_a;
			motor_step_pkg::SEL_PHASE_B: comparator_input = phase_input_b;
			motor_step_pkg::SEL_PHASE_C: comparator_input = phase_input_c;
			default: begin
				// Code 11 leaves the comparator unconnected, read as low
				comparator_input = 1'b0;
				comparator_connected = 1'b0;
			end
		endcase
	end
endmodule

//--- core/channel_output_driver.sv
`timescale 1ns/1ps
module channel_output_driver (
	input wire logic [5:0] channel_on_bits,
	input wire logic [5:0] channel_polarity,
	input wire logic [5:0] pwm_gate,
	input wire logic output_enable,
	output logic [5:0] output_channels,
	output logic [5:0] output_channels_oe_n
);
	// ****************************************
	// Polarity combination
	// ****************************************
	logic [5:0] conducting;
	// Off channel never sees PWM; an on channel conducts while its gate allows
	assign conducting = channel_on_bits & pwm_gate;
	// Polarity 0 is active low, polarity 1 active high
	assign output_channels = ~(conducting ^ channel_polarity);
	assign output_channels_oe_n = {6{~output_enable}};
endmodule

//--- core/motor_step_control.sv
`timescale 1ns/1ps
module motor_step_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic commutation_event,
	input wire logic demag_event,
	input wire logic pwm_in,
	input wire logic phase_input_a,
	input wire logic phase_input_b,
	input wire logic phase_input_c,
	output logic comparator_input,
	output logic comparator_connected,
	output logic [5:0] output_channels,
	output logic [5:0] output_channels_oe_n,
	output logic sample_window,
	output logic zero_cross_same_edge,
	output logic after_demag
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		ACCESS_IDLE = 2'b01,
		ACCESS_DONE = 2'b10
	} access_e;

	access_e access_state;
	logic [7:0] phase_state;
	logic [7:0] phase_state_pre;
	logic [7:0] channel_parity;
	logic [7:0] channel_parity_pre;
	logic [7:0] control;
	logic pre_demag_active;
	logic pre_demag_pre;
	logic [7:0] polarity_reg;
	logic alt_phase;
	logic bus_req;
	logic wr_phase;
	logic wr_parity;
	logic wr_control;
	logic wr_polarity;
	logic direct_access;
	logic load_preload;
	logic [7:0] next_phase_pre;
	logic [7:0] next_parity_pre;
	logic [5:0] pwm_gate;
	logic [5:0] odd_mask;
	logic [5:0] even_mask;
	logic [31:0] next_readdata;

	function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
		input logic [31:0] wdata, input logic [3:0] be);
		merge_byte = be[0] ? wdata[7:0] : old_value;
	endfunction

	function automatic logic [5:0] mode_gate(input logic [1:0] mode, input logic [5:0] ev,
		input logic [5:0] od, input logic alt);
		case (mode)
			motor_step_pkg::MODE_EVEN: mode_gate = ev;
			motor_step_pkg::MODE_ODD: mode_gate = od;
			motor_step_pkg::MODE_ALTERNATE: mode_gate = alt ? od : ev;
			default: mode_gate = ev | od;
		endcase
	endfunction

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// One wait cycle per access: waitrequest is low in the second cycle
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & (access_state == ACCESS_IDLE);

	always_ff @(posedge clk) begin
		if (rst) begin
			access_state <= ACCESS_IDLE;
		end else begin
			case (access_state)
				ACCESS_IDLE: if (bus_req) access_state <= ACCESS_DONE;
				ACCESS_DONE: access_state <= ACCESS_IDLE;
				default: access_state <= ACCESS_IDLE;
			endcase
		end
	end

	assign wr_phase = avs_write & ~avs_waitrequest
		& (avs_address == motor_step_pkg::ADDR_PHASE_STATE);
	assign wr_parity = avs_write & ~avs_waitrequest
		& (avs_address == motor_step_pkg::ADDR_CHANNEL_PARITY);
	assign wr_control = avs_write & ~avs_waitrequest
		& (avs_address == motor_step_pkg::ADDR_CONTROL);
	assign wr_polarity = avs_write & ~avs_waitrequest
		& (avs_address == motor_step_pkg::ADDR_POLARITY);

	always_comb begin
		case (avs_address)
			// Active phase and parity copies are returned; the control read shows the pending pre-demag bit
			motor_step_pkg::ADDR_PHASE_STATE: next_readdata = {24'h000000, phase_state};
			motor_step_pkg::ADDR_CHANNEL_PARITY: next_readdata = {24'h000000, channel_parity};
			motor_step_pkg::ADDR_CONTROL: next_readdata = {24'h000000, control};
			motor_step_pkg::ADDR_POLARITY: next_readdata = {24'h000000, polarity_reg};
			default: next_readdata = motor_step_pkg::READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & (access_state == ACCESS_IDLE)) begin
			avs_readdata <= next_readdata;
		end
	end

	// ****************************************
	// Control and polarity (immediate)
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			control <= motor_step_pkg::CONTROL_RESET;
		end else if (wr_control) begin
			control <= merge_byte(control, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			polarity_reg <= motor_step_pkg::POLARITY_RESET;
		end else if (wr_polarity) begin
			polarity_reg <= merge_byte(polarity_reg, avs_writedata, avs_byteenable);
		end
	end

	assign direct_access = control[motor_step_pkg::CTRL_DIRECT_ACCESS];

	// ****************************************
	// Preload and transfer
	// ****************************************
	// Direct access loads everything on the phase write itself, with the new data
	assign load_preload = direct_access ? wr_phase : commutation_event;
	assign next_phase_pre = wr_phase
		? merge_byte(phase_state_pre, avs_writedata, avs_byteenable) : phase_state_pre;
	assign next_parity_pre = wr_parity
		? merge_byte(channel_parity_pre, avs_writedata, avs_byteenable) : channel_parity_pre;

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_state_pre <= motor_step_pkg::PHASE_STATE_RESET;
			phase_state <= motor_step_pkg::PHASE_STATE_RESET;
		end else begin
			phase_state_pre <= next_phase_pre;
			if (load_preload) phase_state <= next_phase_pre;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			channel_parity_pre <= motor_step_pkg::CHANNEL_PARITY_RESET;
			channel_parity <= motor_step_pkg::CHANNEL_PARITY_RESET;
		end else begin
			channel_parity_pre <= next_parity_pre;
			if (load_preload) channel_parity <= next_parity_pre;
		end
	end

	// Only the pre-demag mode bit of the control register is preloaded
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_demag_pre <= 1'b0;
			pre_demag_active <= 1'b0;
		end else begin
			if (wr_control && avs_byteenable[0]) begin
				pre_demag_pre <= avs_writedata[motor_step_pkg::CTRL_PRE_DEMAG];
			end
			if (load_preload) begin
				pre_demag_active <= (wr_control && avs_byteenable[0])
					? avs_writedata[motor_step_pkg::CTRL_PRE_DEMAG] : pre_demag_pre;
			end
		end
	end

	// ****************************************
	// Step phase tracking
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			after_demag <= 1'b0;
		end else if (commutation_event) begin
			after_demag <= 1'b0;
		end else if (demag_event) begin
			after_demag <= 1'b1;
		end
	end

	// Alternation flips at each PWM period start that closes a sample window, so odd and even share the load
	always_ff @(posedge clk) begin
		if (rst) begin
			alt_phase <= 1'b0;
		end else if (commutation_event) begin
			alt_phase <= 1'b0;
		end else if (pwm_in & ~sample_window) begin
			alt_phase <= alt_phase;
		end else begin
			alt_phase <= alt_phase ^ (pwm_in & sample_window);
		end
	end

	// ****************************************
	// PWM pattern
	// ****************************************
	assign odd_mask = channel_parity[motor_step_pkg::CHANNEL_HI:0];
	assign even_mask = ~channel_parity[motor_step_pkg::CHANNEL_HI:0];

	always_comb begin
		logic [5:0] pwm_set;
		pwm_set = 6'h00;
		if (after_demag || control[motor_step_pkg::CTRL_SENSOR_SELECT]) begin
			pwm_set = mode_gate(control[motor_step_pkg::CTRL_POST_HI:motor_step_pkg::CTRL_POST_LO],
				even_mask, odd_mask, alt_phase);
		end else if (control[motor_step_pkg::CTRL_VOLT_CURR]) begin
			pwm_set = pre_demag_active ? odd_mask : even_mask;
		end else begin
			pwm_set = mode_gate(pre_demag_active ? motor_step_pkg::MODE_ALTERNATE
				: motor_step_pkg::MODE_ALL, even_mask, odd_mask, alt_phase);
		end
		// Channels outside the PWM set stay fully on; those inside follow the carrier
		pwm_gate = ~pwm_set | {6{pwm_in}};
	end

	// ****************************************
	// Back-EMF sampling
	// ****************************************
	// Sampling only makes sense in PWM off time on the selected parity group
	always_ff @(posedge clk) begin
		if (rst) begin
			sample_window <= 1'b0;
		end else begin
			sample_window <= ~pwm_in & |(phase_state[motor_step_pkg::CHANNEL_HI:0]
				& (channel_parity[motor_step_pkg::READ_PARITY_BIT] ? odd_mask : even_mask));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			zero_cross_same_edge <= 1'b0;
		end else begin
			zero_cross_same_edge <= channel_parity[motor_step_pkg::EDGE_RELATION_BIT];
		end
	end

	// ****************************************
	// Instances
	// ****************************************
	phase_input_mux input_mux (
		.input_select(phase_state[motor_step_pkg::INPUT_SELECT_HI:motor_step_pkg::INPUT_SELECT_LO]),
		.phase_input_a(phase_input_a),
		.phase_input_b(phase_input_b),
		.phase_input_c(phase_input_c),
		.comparator_input(comparator_input),
		.comparator_connected(comparator_connected)
	);

	channel_output_driver output_driver (
		.channel_on_bits(phase_state[motor_step_pkg::CHANNEL_HI:0]),
		.channel_polarity(polarity_reg[motor_step_pkg::CHANNEL_HI:0]),
		.pwm_gate(pwm_gate),
		.output_enable(control[motor_step_pkg::CTRL_OUTPUT_ENABLE]),
		.output_channels(output_channels),
		.output_channels_oe_n(output_channels_oe_n)
	);
endmodule

//--- verification/motor_step_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module motor_step_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic commutation_event,
	input wire logic demag_event,
	input wire logic pwm_in,
	input wire logic comparator_input,
	input wire logic comparator_connected,
	input wire logic [5:0] output_channels,
	input wire logic [5:0] output_channels_oe_n,
	input wire logic sample_window,
	input wire logic zero_cross_same_edge,
	input wire logic after_demag
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	sequence all_clear;
		output_channels == 6'h3F && output_channels_oe_n == 6'h3F && avs_readdata == 32'h0;
	endsequence
	wait_state_a: assert property ($rose(avs_read || avs_write) |-> one_wait)
		else $error("bus wait state wrong");
	reset_value_a: assert property ($fell(rst) |-> all_clear)
		else $error("state after reset wrong");
	mux_off_a: assert property (!comparator_connected |-> !comparator_input)
		else $error("comparator driven while unselected");
	demag_set_a: assert property (demag_event && !commutation_event |=> after_demag)
		else $error("demag phase not entered");
	comm_clear_a: assert property (commutation_event |=> !after_demag)
		else $error("demag phase not left");
	demag_hold_a: assert property (!demag_event && !commutation_event |=> $stable(after_demag))
		else $error("demag phase moved alone");
	sample_off_a: assert property (pwm_in |=> !sample_window)
		else $error("sampling during on time");
	// Registered copy may trail the active bit by one more edge
	edge_hold_a: assert property ($changed(zero_cross_same_edge) |-> $past(commutation_event)
		|| $past(commutation_event, 2) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("edge relation moved without load");
endmodule
bind motor_step_control motor_step_monitor motor_step_monitor_i (.*);

//--- verification/phase_bridge_model.sv
`timescale 1ns/1ps
// ****
// Bridge and motor phases
// ****
module phase_bridge_model (
	input wire logic clk,
	input wire logic [5:0] output_channels,
	input wire logic [5:0] output_channels_oe_n,
	input wire logic [5:0] channel_polarity,
	output logic phase_input_a,
	output logic phase_input_b,
	output logic phase_input_c
);
	logic [5:0] on;
	logic [2:0] ph;
	logic flt = 1'h0;
	// An undriven phase wanders, so a stale level never passes for a match
	always @(posedge clk) flt <= ~flt;
	assign on = ~(output_channels ^ channel_polarity) & ~output_channels_oe_n;
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			ph[k] = on[2 * k] ? 1'h1 : (on[2 * k + 1] ? 1'h0 : flt ^ k[0]);
		end
	end
	assign phase_input_a = ph[0];
	assign phase_input_b = ph[1];
	assign phase_input_c = ph[2];
endmodule

//--- verification/motor_phase_output_step_control_bench.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module motor_phase_output_step_control_bench;
	localparam logic [3:0] PS = motor_step_pkg::ADDR_PHASE_STATE;
	localparam logic [3:0] PR = motor_step_pkg::ADDR_CHANNEL_PARITY;
	localparam logic [3:0] CT = motor_step_pkg::ADDR_CONTROL;
	localparam logic [3:0] PL = motor_step_pkg::ADDR_POLARITY;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, comparator_input, comparator_connected;
	logic commutation_event = 1'h0;
	logic demag_event = 1'h0;
	logic pwm_in = 1'h1;
	logic rnd = 1'h0;
	logic snap = 1'h0;
	logic [5:0] channel_polarity = 6'h00;
	logic phase_input_a, phase_input_b, phase_input_c;
	logic sample_window, zero_cross_same_edge, after_demag;
	logic [5:0] output_channels, output_channels_oe_n;
	logic [31:0] rq[$];
	logic [7:0] sq[$];
	int num_errors = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	motor_step_control motor_step_control_i (.*, .avs_byteenable(4'hF));
	phase_bridge_model phase_bridge_model_i (.*);
	// Carrier and demag wander only while pins are not compared
	always @(posedge clk) begin
		pwm_in <= rnd ? 1'($urandom) : 1'h1;
		demag_event <= rnd && ($urandom % 5 == 0);
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish(input logic hang);
		if (hang) num_errors++;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		if (n >= 50) tally_and_finish(1'h1);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rq.push_back({24'h000000, e});
		bus(1'h0, a, 8'h00);
	endtask
	task automatic pulse();
		@(posedge clk);
		commutation_event <= 1'h1;
		@(posedge clk);
		commutation_event <= 1'h0;
	endtask
	task automatic look(input logic [7:0] w);
		sq.push_back(w);
		@(posedge clk);
		snap <= 1'h1;
		@(posedge clk);
		snap <= 1'h0;
	endtask
	always @(posedge clk) begin
		logic [7:0] e;
		logic sel;
		if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
			chk("readdata", rq.pop_front(), avs_readdata);
		end
		if (snap === 1'h1) begin
			e = sq.pop_front();
			sel = e[7:6] == 2'h0 ? phase_input_a : (e[7:6] == 2'h1 ? phase_input_b : phase_input_c);
			chk("pins", 32'({6'h00, ~(e[5:0] ^ channel_polarity)}),
				32'({output_channels_oe_n, output_channels}));
			chk("comparator", 32'({e[7:6] != 2'h3 && sel, e[7:6] != 2'h3}),
				32'({comparator_input, comparator_connected}));
		end
	end
	initial begin
		logic [7:0] w;
		logic [7:0] p;
		logic [7:0] q;
		void'($urandom(32'h978D));
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		for (int a = 0; a < 16; a += 4) rd(4'(a), 8'h00);
		rd(4'h2, 8'h00);
		w = 8'($urandom);
		p = 8'($urandom);
		bus(1'h1, PS, w);
		bus(1'h1, PR, p);
		rd(PS, 8'h00);
		rd(PR, 8'h00);
		pulse();
		rd(PS, w);
		rd(PR, p);
		channel_polarity = 6'($urandom);
		bus(1'h1, PL, {2'h0, channel_polarity});
		bus(1'h1, CT, 8'h41);
		q = 8'($urandom);
		bus(1'h1, PR, q);
		rd(PR, p);
		for (int c = 0; c < 4; c++) begin
			w = {2'(c), 6'($urandom)};
			bus(1'h1, PS, w);
			look(w);
			rd(PS, w);
		end
		rd(PR, q);
		bus(1'h1, CT, 8'h40);
		p = {2'h0, ~w[5:0]};
		bus(1'h1, PS, p);
		look(w);
		pulse();
		look(p);
		rnd <= 1'h1;
		for (int m = 0; m < 32; m++) begin
			bus(1'h1, CT, {2'h1, 5'(m), 1'h0});
			repeat (20) @(posedge clk);
			pulse();
		end
		rnd <= 1'h0;
		repeat (3) @(posedge clk);
		// Parity preload still holds q, so its edge bit is now the active one
		chk("edge_relation", 32'(q[7]), 32'(zero_cross_same_edge));
		tally_and_finish(1'h0);
	end
endmodule
